// ---- mpp_map.svh ----
// Constants for the muxed parallel memory port: widths, timing counts, reset values.
// Assumes inclusion by the package and the design modules only.
`ifndef MPP_MAP_SVH
`define MPP_MAP_SVH
`define MPP_ADDR_W        24
`define MPP_BUS_W         16
`define MPP_HIGH_LSB      8
`define MPP_LATCH_CYC     2
`define MPP_STROBE_CYC    2
`define MPP_LATCH_POL_RST 1'b1
`define MPP_WIDE_RST      1'b0
`endif

// ---- mpp_pkg.sv ----
// Types for the muxed parallel memory port.
// Assumes mpp_map.svh is on the include path.
`include "mpp_map.svh"
package mpp_pkg;
  typedef enum logic [2:0] {
    MPP_IDLE   = 3'b000,
    MPP_LATCH  = 3'b001,
    MPP_READ   = 3'b010,
    MPP_WRITE  = 3'b011,
    MPP_DONE   = 3'b100
  } mpp_state_e;
  typedef logic [`MPP_ADDR_W-1:0] mpp_addr_t;
endpackage

// ---- mpp_skid.sv ----
// Two-entry buffer with valid/ready on both sides for read data.
// Assumes one clock, synchronous reset and a clock enable.
`timescale 1ns/1ps
module mpp_skid #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_ce,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  typedef struct packed {
    logic [1:0]   cnt;
    logic         valid;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } mpp_skid_s;
  mpp_skid_s s_q, s_d;
  logic push, pop;
  always_comb begin
    s_d = s_q;
    push = i_in_valid && (s_q.cnt != 2'h2);
    pop  = i_out_ready && (s_q.cnt != 2'h0);
    if (pop) begin
      s_d.e0 = s_q.e1;
    end
    if (push) begin
      if ((s_q.cnt == 2'h0) || (s_q.cnt == 2'h1 && pop)) begin
        s_d.e0 = i_in_data;
      end else begin
        s_d.e1 = i_in_data;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    // Registered copy so the output comes straight from a flop
    s_d.valid = (s_d.cnt != 2'h0);
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end
  assign o_in_ready  = (s_q.cnt != 2'h2);
  assign o_out_valid = s_q.valid;
  assign o_out_data  = s_q.e0;
  a_skid_no_over: assert property (@(posedge i_clk) disable iff (i_srst) s_q.cnt != 2'h3)
    else $error("buffer count overflow");
endmodule

// ---- mpp_port.sv ----
// Muxed parallel memory port: address/data multiplexing, latch strobe, read/write strobes.
// Assumes a core-side request interface and an external address latch on the board.
`timescale 1ns/1ps
`include "mpp_map.svh"
module mpp_port #(
  parameter int LATCH_CYC  = `MPP_LATCH_CYC,
  parameter int STROBE_CYC = `MPP_STROBE_CYC
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ce,
  input  wire logic                    i_wide_mode,
  input  wire logic                    i_latch_active_low,
  input  wire logic                    i_flag_mode,
  input  wire logic                    i_req_valid,
  output logic                         o_req_ready,
  input  wire logic                    i_req_write,
  input  wire mpp_pkg::mpp_addr_t      i_req_addr,
  input  wire logic [`MPP_BUS_W-1:0]   i_req_wdata,
  output logic                         o_rd_valid,
  input  wire logic                    i_rd_ready,
  output logic [`MPP_BUS_W-1:0]        o_rd_data,
  input  wire logic [`MPP_BUS_W-1:0]   i_muxed_bus_lines,
  output logic [`MPP_BUS_W-1:0]        o_muxed_bus_lines,
  output logic                         o_muxed_bus_oe,
  output logic                         o_rd_n,
  output logic                         o_wr_n,
  output logic                         o_latch
);
  import mpp_pkg::*;

  typedef struct packed {
    mpp_state_e                         st;
    logic [7:0]                         cnt;
    logic                               wr;
    mpp_addr_t                          addr;
    logic [`MPP_ADDR_W-`MPP_HIGH_LSB-1:0] last_high;
    logic                               high_valid;
    logic [`MPP_BUS_W-1:0]              wdata;
    logic                               latch_pol_hi;
    logic                               ready;
    logic [`MPP_BUS_W-1:0]              bus_out;
    logic                               bus_oe;
    logic                               rd_n;
    logic                               wr_n;
    logic                               latch;
    logic                               cap;
    logic [`MPP_BUS_W-1:0]              cap_data;
  } mpp_port_s;

  localparam logic [7:0] LATCH_LAST  = 8'(LATCH_CYC - 1);
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

  mpp_port_s s_q, s_d;
  logic      buf_ready;
  logic      latch_on;
  logic      need_latch;

  mpp_skid #(
    .W (`MPP_BUS_W)
  ) u_skid (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_ce        (i_ce),
    .i_in_valid  (s_q.cap),
    .o_in_ready  (buf_ready),
    .i_in_data   (s_q.cap_data),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );

  always_comb begin
    s_d = s_q;
    s_d.cap = 1'b0;
    // Same polarity that is registered alongside the new access
    latch_on = (s_q.st == MPP_IDLE) ? !i_latch_active_low : s_q.latch_pol_hi;
    need_latch = i_wide_mode || !s_q.high_valid ||
                 (i_req_addr[`MPP_ADDR_W-1:`MPP_HIGH_LSB] != s_q.last_high);
    // Polarity only changes while the bus is quiet, so no false latch edge
    if (s_q.st == MPP_IDLE) begin
      s_d.latch_pol_hi = !i_latch_active_low;
      s_d.latch = i_latch_active_low;
    end
    s_d.ready = 1'b0;
    unique case (s_q.st)
      MPP_IDLE: begin
        s_d.rd_n = 1'b1;
        s_d.wr_n = 1'b1;
        s_d.bus_oe = 1'b0;
        if (!i_flag_mode && i_req_valid && s_q.ready && buf_ready) begin
          s_d.wr = i_req_write;
          s_d.addr = i_req_addr;
          s_d.wdata = i_req_wdata;
          s_d.cnt = 8'h00;
          if (need_latch) begin
            s_d.st = MPP_LATCH;
            s_d.latch = latch_on;
            s_d.bus_oe = 1'b1;
            s_d.bus_out = i_wide_mode ? i_req_addr[`MPP_BUS_W-1:0]
                                      : i_req_addr[`MPP_ADDR_W-1:`MPP_HIGH_LSB];
            s_d.last_high = i_req_addr[`MPP_ADDR_W-1:`MPP_HIGH_LSB];
            s_d.high_valid = !i_wide_mode;
          end else begin
            s_d.st = i_req_write ? MPP_WRITE : MPP_READ;
            s_d.rd_n = i_req_write;
            s_d.wr_n = !i_req_write;
            s_d.bus_oe = i_req_write;
            s_d.bus_out = {8'h00, i_req_wdata[7:0]};
          end
        end else begin
          // Ready only offered when a take could follow
          s_d.ready = !i_flag_mode && buf_ready;
        end
      end
      MPP_LATCH: begin
        if (s_q.cnt == LATCH_LAST) begin
          s_d.cnt = 8'h00;
          s_d.latch = !s_q.latch_pol_hi;
          s_d.st = s_q.wr ? MPP_WRITE : MPP_READ;
          s_d.rd_n = s_q.wr;
          s_d.wr_n = !s_q.wr;
          s_d.bus_oe = s_q.wr;
          s_d.bus_out = i_wide_mode ? s_q.wdata : {8'h00, s_q.wdata[7:0]};
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      MPP_READ, MPP_WRITE: begin
        if (s_q.cnt == STROBE_LAST) begin
          if (s_q.st == MPP_READ) begin
            s_d.cap = 1'b1;
            s_d.cap_data = i_wide_mode ? i_muxed_bus_lines : {8'h00, i_muxed_bus_lines[7:0]};
          end
          s_d.rd_n = 1'b1;
          s_d.wr_n = 1'b1;
          s_d.st = MPP_DONE;
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      MPP_DONE: begin
        s_d.bus_oe = 1'b0;
        s_d.st = MPP_IDLE;
      end
      default: begin
        s_d.st = MPP_IDLE;
      end
    endcase
    if (i_flag_mode) begin
      s_d.rd_n = 1'b1;
      s_d.wr_n = 1'b1;
      s_d.latch = !s_d.latch_pol_hi;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
      s_q.st <= MPP_IDLE;
      s_q.latch_pol_hi <= `MPP_LATCH_POL_RST;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
      s_q.latch <= 1'b0;
      s_q.bus_oe <= 1'b0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_req_ready       = s_q.ready;
  assign o_muxed_bus_lines = s_q.bus_out;
  assign o_muxed_bus_oe    = s_q.bus_oe;
  assign o_rd_n            = s_q.rd_n;
  assign o_wr_n            = s_q.wr_n;
  assign o_latch           = s_q.latch;

  sequence s_latch_phase;
    (o_latch == s_q.latch_pol_hi) [*2];
  endsequence
  sequence s_data_phase;
    (o_latch != s_q.latch_pol_hi) && (!o_rd_n || !o_wr_n);
  endsequence

  a_rd_wr_excl: assert property (@(posedge i_clk) disable iff (i_srst) !(!o_rd_n && !o_wr_n))
    else $error("read and write strobes both low");
  a_strobe_no_latch: assert property (@(posedge i_clk) disable iff (i_srst)
    (!o_rd_n || !o_wr_n) |-> o_latch != s_q.latch_pol_hi)
    else $error("strobe during latch phase");
  a_latch_then_data: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.st == MPP_LATCH && $past(s_q.st) == MPP_IDLE) |-> s_latch_phase ##1 s_data_phase)
    else $error("latch phase not followed by data phase");
  a_flag_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    ($past(i_flag_mode) && $past(i_ce) && i_flag_mode) |-> (o_rd_n && o_wr_n && o_latch != s_q.latch_pol_hi))
    else $error("strobe active in flag mode");
  a_reset_levels: assert property (@(posedge i_clk)
    $fell(i_srst) |-> (o_rd_n && o_wr_n && !o_latch && !o_muxed_bus_oe))
    else $error("wrong levels after reset");
  a_reset_pol: assert property (@(posedge i_clk) $fell(i_srst) |-> s_q.latch_pol_hi)
    else $error("latch polarity not high after reset");
  a_read_undriven: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_rd_n |-> !o_muxed_bus_oe)
    else $error("bus driven during read");
  a_read_len: assert property (@(posedge i_clk) disable iff (i_srst)
    ($fell(o_rd_n) && i_ce) |-> ##1 (!i_ce || !o_rd_n))
    else $error("read strobe too short");
  a_narrow_skip: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.st == MPP_IDLE && s_d.st == MPP_READ && i_ce) |-> !i_wide_mode)
    else $error("wide access without latch phase");
  a_wide_wr_latch: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.st == MPP_IDLE && s_d.st == MPP_WRITE && i_ce) |-> !i_wide_mode)
    else $error("wide write without latch phase");
  a_write_drives: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_wr_n |-> o_muxed_bus_oe)
    else $error("bus not driven during write");
  a_write_len: assert property (@(posedge i_clk) disable iff (i_srst)
    ($fell(o_wr_n) && i_ce) |-> ##1 (!i_ce || !o_wr_n))
    else $error("write strobe too short");
  a_latch_drives: assert property (@(posedge i_clk) disable iff (i_srst)
    (s_q.st == MPP_LATCH && !$past(i_flag_mode)) |-> (o_muxed_bus_oe && o_latch == s_q.latch_pol_hi))
    else $error("latch phase without address on the bus");
  a_flag_no_take: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_flag_mode && s_q.st == MPP_IDLE) |-> (s_d.st == MPP_IDLE))
    else $error("access started in flag mode");
  a_ready_idle: assert property (@(posedge i_clk) disable iff (i_srst)
    o_req_ready |-> (s_q.st == MPP_IDLE))
    else $error("ready outside idle");
endmodule

// ---- mpp_mem_model.sv ----
// Behavioural memory behind a board address latch for the muxed port.
// Assumes the bench resolves the shared bus lines and hands in latch activity.
`timescale 1ns/1ps
module mpp_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_latch_act,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [15:0] i_bus,
  output logic             o_drv,
  output logic [15:0]      o_dat
);
  logic [15:0] hold_q;
  logic [15:0] mem [16];
  always_ff @(posedge i_clk) begin
    if (i_latch_act) begin
      hold_q <= i_bus;
    end
    if (!i_wr_n) begin
      mem[hold_q[3:0]] <= i_bus;
    end
  end
  assign o_drv = !i_rd_n;
  assign o_dat = mem[hold_q[3:0]];
endmodule

// ---- tb_muxed_parallel_memory_port.sv ----
// Self-checking bench for the muxed parallel memory port.
// Assumes mpp_pkg and mpp_mem_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_muxed_parallel_memory_port;
  import mpp_pkg::*;
  logic i_clk = 0, i_srst = 1, wide = 0, pol = 0, flag = 0, vld = 0, wr = 0, rdy = 0, ce = 1;
  mpp_addr_t addr = '0;
  logic [15:0] wdat = '0, o_bus, o_rdd, bus, m_dat;
  logic o_oe, o_rd_n, o_wr_n, o_latch, o_rdy, o_rdv, m_drv, lat_act;
  int errors = 0, checks = 0, lat_n, rd_c, wr_c;
  logic [15:0] lat_bus;
  assign lat_act = o_latch ^ pol;
  assign bus = o_oe ? o_bus : (m_drv ? m_dat : 16'hFFFF);
  mpp_port DUT (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_wide_mode(wide),
    .i_latch_active_low(pol), .i_flag_mode(flag), .i_req_valid(vld), .o_req_ready(o_rdy),
    .i_req_write(wr), .i_req_addr(addr), .i_req_wdata(wdat), .o_rd_valid(o_rdv),
    .i_rd_ready(rdy), .o_rd_data(o_rdd), .i_muxed_bus_lines(bus), .o_muxed_bus_lines(o_bus),
    .o_muxed_bus_oe(o_oe), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_latch(o_latch));
  mpp_mem_model MEM (.i_clk(i_clk), .i_latch_act(lat_act), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .i_bus(bus), .o_drv(m_drv), .o_dat(m_dat));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One access; latch cycles, bus during latch and strobe cycles are judged
  task automatic acc(input logic w, input mpp_addr_t a, input logic [15:0] d, input int exp_lat,
                     input logic [15:0] exp_bus);
    int n;
    n = 0;
    while (o_rdy !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    `CHK(o_rdy, 1'b1)
    vld = 1;
    wr = w;
    addr = a;
    wdat = d;
    step(1);
    vld = 0;
    lat_n = 0;
    rd_c = 0;
    wr_c = 0;
    repeat (12) begin
      if (lat_act === 1'b1) begin
        lat_n++;
        lat_bus = bus;
      end
      if (o_rd_n === 1'b0) rd_c++;
      if (o_wr_n === 1'b0) wr_c++;
      step(1);
    end
    `CHK(lat_n, exp_lat)
    if (exp_lat > 0) `CHK(lat_bus, exp_bus)
    `CHK(rd_c, w ? 0 : 2)
    `CHK(wr_c, w ? 2 : 0)
  endtask
  task automatic take(input logic [15:0] exp, input logic [15:0] mask);
    int n;
    n = 0;
    while (o_rdv !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    `CHK(o_rdv, 1'b1)
    `CHK(o_rdd & mask, exp)
    rdy = 1;
    step(1);
    rdy = 0;
  endtask
  task automatic t_reset();
    `CHK({o_rd_n, o_wr_n, o_latch, o_oe}, 4'hC)
  endtask
  // Frozen port ignores a request and a polarity change
  task automatic t_freeze();
    ce = 0;
    pol = 1;
    vld = 1;
    step(4);
    `CHK({o_rdy, o_latch}, 2'h2)
    ce = 1;
    pol = 0;
    vld = 0;
    step(2);
    `CHK({o_rd_n, o_latch}, 2'h2)
  endtask
  task automatic t_wide();
    wide = 1;
    acc(1, 24'h000003, 16'hBEEF, 2, 16'h0003);
    acc(1, 24'h000005, 16'h1234, 2, 16'h0005);
    acc(0, 24'h000003, 16'h0000, 2, 16'h0003);
    acc(0, 24'h000005, 16'h0000, 2, 16'h0005);
    repeat (8) begin
      `CHK(o_rdy, 1'b0)
      step(1);
    end
    take(16'hBEEF, 16'hFFFF);
    take(16'h1234, 16'hFFFF);
  endtask
  task automatic t_narrow();
    wide = 0;
    acc(1, 24'h123400, 16'h005A, 2, 16'h1234);
    acc(1, 24'h123401, 16'h00C3, 0, 16'h0000);
    acc(0, 24'h123401, 16'h0000, 0, 16'h0000);
    take(16'h00C3, 16'h00FF);
    acc(1, 24'h567800, 16'h0011, 2, 16'h5678);
  endtask
  task automatic t_flag();
    flag = 1;
    step(1);
    vld = 1;
    repeat (10) begin
      step(1);
      `CHK({o_rdy, o_rd_n, o_wr_n, lat_act}, 4'h6)
    end
    vld = 0;
    flag = 0;
  endtask
  task automatic t_pol();
    pol = 1;
    step(3);
    `CHK(o_latch, 1'b1)
    wide = 1;
    acc(1, 24'h000009, 16'hA55A, 2, 16'h0009);
    pol = 0;
    step(3);
  endtask
  initial begin
    step(5);
    i_srst = 0;
    t_reset();
    step(2);
    t_freeze();
    t_wide();
    t_narrow();
    t_flag();
    t_pol();
    close_out();
  end
  initial begin
    #(50 * 3000);
    errors++;
    close_out();
  end
endmodule
